// [design/scr_map.svh]
// register offsets, field positions, reset values and timing counts
// assumes byte offsets on the serial control bus register port
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

`define SCR_A_OWN_ADDR 8'h00
`define SCR_A_RESETS 8'h01
`define SCR_A_GEN_CFG 8'h03
`define SCR_A_FAILSAFE 8'h04
`define SCR_A_BUS_CTL 8'h05
`define SCR_A_REMOTE_RX 8'h06
`define SCR_A_TGT0 8'h07
`define SCR_A_ALIAS0 8'h08
`define SCR_A_CRC_LO 8'h0A
`define SCR_A_CRC_HI 8'h0B
`define SCR_A_STATUS 8'h0C
`define SCR_A_PIN0 8'h0D
`define SCR_A_PIN12 8'h0E

`define SCR_B_ADDR_SEL 0
`define SCR_B_SLEEP 7
`define SCR_B_VID_RST 4
`define SCR_B_FULL_RST 1
`define SCR_B_LOGIC_RST 0
`define SCR_B_CRC_EN 7
`define SCR_B_AUTO_ACK 5
`define SCR_B_SYNC_FILT 4
`define SCR_B_PASS 3
`define SCR_B_CLK_AUTO 1
`define SCR_B_FS_LOW 7
`define SCR_B_CRC_CLR 5
`define SCR_B_REM_BLOCK 2
`define SCR_B_BC_DIS 0
`define SCR_B_HOLD_REM 0

`define SCR_GEN_CFG_RST 8'hD2
`define SCR_FAILSAFE_RST 8'h80
`define SCR_ZERO_RST 8'h00

`define SCR_CLK_NS 100
`define SCR_SOFT_RST_CYCLES 8
`define SCR_IDLE_NS 1000000000
`define SCR_SCL_HALF_NS 5000
`define SCR_SDA_BASE_NS 240
`define SCR_SDA_STEP_NS 40
`define SCR_CLEAR_PULSES 9

`endif

// [design/scr_pkg.sv]
// types shared by the control register bank
// assumes the constants of scr_map.svh
package scr_pkg;

  typedef enum logic [2:0]
  {
    SCR_BC_WATCH = 3'b001,
    SCR_BC_LOW = 3'b010,
    SCR_BC_HIGH = 3'b100
  } scr_bc_state_t;

endpackage

// [design/scr_gpio_pin.sv]
// one general-purpose pin: mode decode and remote hold/default
// assumes link_up and remote_val come from logic on clk_sys
`timescale 1ns/10ps
module scr_gpio_pin #(
  parameter bit FUNC_IN = 1'b0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [2:0] mode,
  input wire logic out_val,
  input wire logic remote_val,
  input wire logic link_up,
  output logic pin_out_ff,
  output logic pin_oe_ff,
  output logic func_in_ff
);

  wire is_local = (mode == 3'b001);
  wire is_remote = mode[0] & mode[2];
  wire hold_mode = (mode == 3'b101);
  wire func_sel = FUNC_IN & (mode[1:0] == 2'b00);
  // hold mode keeps the last driven value while the link is down
  wire remote_pick = link_up ? remote_val
                   : (hold_mode ? pin_out_ff : out_val);
  wire nxt_out = is_remote ? remote_pick : (is_local & out_val);
  wire nxt_oe = is_local | is_remote;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      func_in_ff <= 1'b0;
    end
    else
    begin
      pin_out_ff <= nxt_out;
      pin_oe_ff <= nxt_oe;
      func_in_ff <= func_sel;
    end
  end

  AST_PIN_DEFAULT: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mode == 3'b111 && !link_up) |=> pin_out_ff == $past(out_val))
    else $error("remote-default pin did not fall back to local value");

endmodule

// [design/scr_regs.sv]
// control register bank of the serializer bridge, offsets 0x00 to 0x0E
// assumes a serial bus front end presents one-cycle register requests
// Functional notes
// - address from strap or programmed field
// - sleep bit powers down without link
// - video input reset bit, self clearing
// - full and logic-only resets, self clearing
// - crc checker enable, config resets 0xD2
// - auto-acknowledge remote writes
// - sync filter drops short pulses
// - alias matches forwarded to remote
// - oscillator takes over without pixel clock
// - failsafe level select, default low
// - crc reset bit holds counters clear
// - sda output delay 240 to 360 ns
// - block remote writes to local registers
// - idle bus free, stuck sda nine clocks
// - remote address autoload unless held
// - alias remapped to target, zero disables
// - sixteen bit crc error counter
// - sticky link lost flag
// - bist crc flag and its clears
// - status flags for crc, clock, link
// - pin zero mode decode
// - pin two mode decode
`timescale 1ns/10ps
`include "scr_map.svh"
module scr_regs #(
  parameter int IDLE_CYCLES = `SCR_IDLE_NS / `SCR_CLK_NS,
  parameter logic [3:0] REVISION = 4'h1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic reg_remote,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  output logic reg_ack_ff,
  output logic reg_refused_ff,
  input wire logic [6:0] address_strap_pin,
  input wire logic mode_strap_zero,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out_ff,
  output logic scl_oe_ff,
  output logic bus_free_ff,
  input wire logic link_detect,
  input wire logic rx_lock,
  input wire logic [6:0] remote_rx_addr,
  input wire logic crc_error,
  input wire logic bist_active,
  input wire logic bist_start,
  input wire logic pclk_present,
  input wire logic xl_req,
  input wire logic [6:0] xl_addr,
  output logic xl_done_ff,
  output logic xl_fwd_ff,
  output logic [6:0] xl_addr_ff,
  input wire logic [2:0] gpio_remote,
  output logic [2:0] gpio_out,
  output logic [2:0] gpio_oe,
  output logic pin2_func_in,
  output logic [6:0] own_bus_address_ff,
  output logic power_down_ff,
  output logic video_reset_ff,
  output logic logic_reset_ff,
  output logic crc_check_en_ff,
  output logic auto_ack_ff,
  output logic sync_filter_en_ff,
  output logic use_osc_ff,
  output logic failsafe_low_ff,
  output logic [8:0] sda_delay_ns_ff
);

  localparam int IW = $clog2(IDLE_CYCLES + 1);
  localparam int HALF = `SCR_SCL_HALF_NS / `SCR_CLK_NS;
  localparam logic [3:0] SOFT_N = 4'(`SCR_SOFT_RST_CYCLES);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // pin synchronisers; scl and sda reset to their idle high, no false edge
  logic [9:0] pin_s1_ff;
  logic [9:0] pin_s2_ff;
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_s1_ff <= 10'h003;
      pin_s2_ff <= 10'h003;
    end
    else
    begin
      pin_s1_ff <= {mode_strap_zero, address_strap_pin, sda_in, scl_in};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  wire scl_s = pin_s2_ff[0];
  wire sda_s = pin_s2_ff[1];

  // straps are caught once the synchronisers have settled after release
  logic [1:0] strap_cnt_ff;
  logic strap_done_ff;
  logic [6:0] strap_addr_ff;
  wire strap_take = !strap_done_ff && (strap_cnt_ff == 2'h2);

  // register storage
  logic [7:0] addr_ff;
  logic sleep_ff;
  logic [7:0] gcfg_ff;
  logic [7:0] fsel_ff;
  logic [4:0] bctl_ff;
  logic [7:0] rxid_ff;
  logic [7:1] tgt_ff;
  logic [7:1] alias_ff;
  logic [3:0] pin0_ff;
  logic [7:0] pin12_ff;
  logic [15:0] crc_cnt_ff;
  logic link_lost_ff;
  logic bist_err_ff;
  logic des_err_ff;
  logic link_prev_ff;
  logic lock_prev_ff;
  logic [3:0] vid_cnt_ff;
  logic [3:0] dig_cnt_ff;
  logic full_busy_ff;

  wire blocked = reg_remote && bctl_ff[`SCR_B_REM_BLOCK];
  wire wr = reg_req && reg_we && !blocked;
  wire wr_own = wr && (reg_addr == `SCR_A_OWN_ADDR);
  wire wr_rst = wr && (reg_addr == `SCR_A_RESETS);
  wire wr_gcfg = wr && (reg_addr == `SCR_A_GEN_CFG);
  wire wr_fsel = wr && (reg_addr == `SCR_A_FAILSAFE);
  wire wr_bctl = wr && (reg_addr == `SCR_A_BUS_CTL);
  wire wr_rxid = wr && (reg_addr == `SCR_A_REMOTE_RX);
  wire wr_tgt = wr && (reg_addr == `SCR_A_TGT0);
  wire wr_alias = wr && (reg_addr == `SCR_A_ALIAS0);
  wire wr_pin0 = wr && (reg_addr == `SCR_A_PIN0);
  wire wr_pin12 = wr && (reg_addr == `SCR_A_PIN12);
  wire full_clr = wr_rst && reg_wdata[`SCR_B_FULL_RST];
  wire vid_go = wr_rst && reg_wdata[`SCR_B_VID_RST];
  wire dig_go = wr_rst && (reg_wdata[`SCR_B_LOGIC_RST] || full_clr);
  wire crc_clr = fsel_ff[`SCR_B_CRC_CLR];
  wire link_fall = link_prev_ff && !link_detect;
  wire lock_rise = rx_lock && !lock_prev_ff;
  wire crc_hit = crc_error && gcfg_ff[`SCR_B_CRC_EN];

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      strap_addr_ff <= 7'h00;
    end
    else if (strap_take)
    begin
      strap_done_ff <= 1'b1;
      strap_addr_ff <= pin_s2_ff[8:2];
    end
    else if (!strap_done_ff)
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_ff <= `SCR_ZERO_RST;
      sleep_ff <= 1'b0;
      gcfg_ff <= `SCR_GEN_CFG_RST;
      fsel_ff <= `SCR_FAILSAFE_RST;
      bctl_ff <= 5'h00;
      rxid_ff <= `SCR_ZERO_RST;
      tgt_ff <= 7'h00;
      alias_ff <= 7'h00;
      pin0_ff <= 4'h0;
      pin12_ff <= `SCR_ZERO_RST;
    end
    else if (full_clr || strap_take)
    begin
      addr_ff <= {strap_done_ff ? strap_addr_ff : pin_s2_ff[8:2], 1'b0};
      sleep_ff <= strap_done_ff ? sleep_ff : pin_s2_ff[9];
      gcfg_ff <= `SCR_GEN_CFG_RST;
      fsel_ff <= `SCR_FAILSAFE_RST;
      bctl_ff <= 5'h00;
      rxid_ff <= `SCR_ZERO_RST;
      tgt_ff <= 7'h00;
      alias_ff <= 7'h00;
      pin0_ff <= 4'h0;
      pin12_ff <= `SCR_ZERO_RST;
    end
    else
    begin
      if (wr_own)
        addr_ff <= reg_wdata;
      if (wr_rst)
        sleep_ff <= reg_wdata[`SCR_B_SLEEP];
      if (wr_gcfg)
        gcfg_ff <= reg_wdata & 8'hBA;
      if (wr_fsel)
        fsel_ff <= reg_wdata & 8'hA0;
      if (wr_bctl)
        bctl_ff <= reg_wdata[4:0];
      if (wr_rxid)
        rxid_ff <= reg_wdata;
      else if (lock_rise && !rxid_ff[`SCR_B_HOLD_REM])
        rxid_ff[7:1] <= remote_rx_addr;
      if (wr_tgt)
        tgt_ff <= reg_wdata[7:1];
      if (wr_alias)
        alias_ff <= reg_wdata[7:1];
      if (wr_pin0)
        pin0_ff <= reg_wdata[3:0];
      if (wr_pin12)
        pin12_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      vid_cnt_ff <= 4'h0;
      dig_cnt_ff <= 4'h0;
      full_busy_ff <= 1'b0;
    end
    else
    begin
      vid_cnt_ff <= vid_go ? SOFT_N
                  : (vid_cnt_ff != 4'h0 ? vid_cnt_ff - 4'h1 : 4'h0);
      dig_cnt_ff <= dig_go ? SOFT_N
                  : (dig_cnt_ff != 4'h0 ? dig_cnt_ff - 4'h1 : 4'h0);
      if (full_clr)
        full_busy_ff <= 1'b1;
      else if (dig_cnt_ff == 4'h1)
        full_busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      crc_cnt_ff <= 16'h0000;
      link_lost_ff <= 1'b0;
      bist_err_ff <= 1'b0;
      des_err_ff <= 1'b0;
      link_prev_ff <= 1'b0;
      lock_prev_ff <= 1'b0;
    end
    else
    begin
      link_prev_ff <= link_detect;
      lock_prev_ff <= rx_lock;
      if (crc_clr)
        crc_cnt_ff <= 16'h0000;
      else if (crc_hit && crc_cnt_ff != 16'hFFFF)
        crc_cnt_ff <= crc_cnt_ff + 16'h0001;
      // a new event beats a clear in the same cycle
      link_lost_ff <= link_fall || (link_lost_ff && !crc_clr);
      bist_err_ff <= (crc_hit && bist_active)
        || (bist_err_ff && !(crc_clr || link_fall || bist_start));
      des_err_ff <= (crc_hit && !bist_active)
        || (des_err_ff && !(crc_clr || link_fall));
    end
  end

  scr_pkg::scr_bc_state_t bc_state_ff;
  logic [IW-1:0] idle_cnt_ff;
  logic [15:0] half_cnt_ff;
  logic [3:0] pulse_cnt_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;
  wire bc_en = !bctl_ff[`SCR_B_BC_DIS];
  wire activity = (scl_s != scl_prev_ff) || (sda_s != sda_prev_ff);
  wire idle_up = (idle_cnt_ff == IW'(IDLE_CYCLES - 1));
  wire half_up = (half_cnt_ff == 16'(HALF - 1));
  wire last_pulse = (pulse_cnt_ff == 4'(`SCR_CLEAR_PULSES - 1));

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      bc_state_ff <= scr_pkg::SCR_BC_WATCH;
      idle_cnt_ff <= '0;
      half_cnt_ff <= 16'h0000;
      pulse_cnt_ff <= 4'h0;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      bus_free_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
    end
    else
    begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
      unique case (bc_state_ff)
        scr_pkg::SCR_BC_WATCH:
        begin
          half_cnt_ff <= 16'h0000;
          pulse_cnt_ff <= 4'h0;
          if (!bc_en || activity)
          begin
            idle_cnt_ff <= '0;
            bus_free_ff <= 1'b0;
          end
          else if (idle_up)
          begin
            idle_cnt_ff <= '0;
            bus_free_ff <= sda_s;
            if (!sda_s)
            begin
              bc_state_ff <= scr_pkg::SCR_BC_LOW;
              scl_oe_ff <= 1'b1;
            end
          end
          else
            idle_cnt_ff <= idle_cnt_ff + IW'(1);
        end
        scr_pkg::SCR_BC_LOW:
        begin
          half_cnt_ff <= half_up ? 16'h0000 : half_cnt_ff + 16'h0001;
          if (half_up)
          begin
            scl_oe_ff <= 1'b0;
            bc_state_ff <= scr_pkg::SCR_BC_HIGH;
          end
        end
        scr_pkg::SCR_BC_HIGH:
        begin
          half_cnt_ff <= half_up ? 16'h0000 : half_cnt_ff + 16'h0001;
          if (half_up && last_pulse)
            bc_state_ff <= scr_pkg::SCR_BC_WATCH;
          else if (half_up)
          begin
            pulse_cnt_ff <= pulse_cnt_ff + 4'h1;
            scl_oe_ff <= 1'b1;
            bc_state_ff <= scr_pkg::SCR_BC_LOW;
          end
        end
        default:
          bc_state_ff <= scr_pkg::SCR_BC_WATCH;
      endcase
    end
  end

  wire alias_hit = gcfg_ff[`SCR_B_PASS] && (alias_ff != 7'h00)
    && (tgt_ff != 7'h00) && (xl_addr == alias_ff);

  wire [7:0] rd_reset = {sleep_ff, 2'b00, vid_cnt_ff != 4'h0, 2'b00,
    full_busy_ff, dig_cnt_ff != 4'h0 && !full_busy_ff};
  wire [7:0] rd_status = {3'b000, link_lost_ff, bist_err_ff,
    pclk_present, des_err_ff, link_detect};
  wire [7:0] rd_val =
    (reg_addr == `SCR_A_OWN_ADDR) ? addr_ff :
    (reg_addr == `SCR_A_RESETS) ? rd_reset :
    (reg_addr == `SCR_A_GEN_CFG) ? gcfg_ff :
    (reg_addr == `SCR_A_FAILSAFE) ? fsel_ff :
    (reg_addr == `SCR_A_BUS_CTL) ? {3'b000, bctl_ff} :
    (reg_addr == `SCR_A_REMOTE_RX) ? rxid_ff :
    (reg_addr == `SCR_A_TGT0) ? {tgt_ff, 1'b0} :
    (reg_addr == `SCR_A_ALIAS0) ? {alias_ff, 1'b0} :
    (reg_addr == `SCR_A_CRC_LO) ? crc_cnt_ff[7:0] :
    (reg_addr == `SCR_A_CRC_HI) ? crc_cnt_ff[15:8] :
    (reg_addr == `SCR_A_STATUS) ? rd_status :
    (reg_addr == `SCR_A_PIN0) ? {REVISION, pin0_ff} :
    (reg_addr == `SCR_A_PIN12) ? pin12_ff : 8'h00;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata_ff <= 8'h00;
      reg_ack_ff <= 1'b0;
      reg_refused_ff <= 1'b0;
      xl_done_ff <= 1'b0;
      xl_fwd_ff <= 1'b0;
      xl_addr_ff <= 7'h00;
      scl_out_ff <= 1'b0;
    end
    else
    begin
      reg_ack_ff <= reg_req;
      reg_refused_ff <= reg_req && reg_we && blocked;
      if (reg_req && !reg_we)
        reg_rdata_ff <= rd_val;
      xl_done_ff <= xl_req;
      if (xl_req)
      begin
        xl_fwd_ff <= alias_hit;
        xl_addr_ff <= alias_hit ? tgt_ff : xl_addr;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      own_bus_address_ff <= 7'h00;
      power_down_ff <= 1'b0;
      video_reset_ff <= 1'b0;
      logic_reset_ff <= 1'b0;
      crc_check_en_ff <= 1'b1;
      auto_ack_ff <= 1'b0;
      sync_filter_en_ff <= 1'b1;
      use_osc_ff <= 1'b0;
      failsafe_low_ff <= 1'b1;
      sda_delay_ns_ff <= 9'(`SCR_SDA_BASE_NS);
    end
    else
    begin
      own_bus_address_ff <= addr_ff[`SCR_B_ADDR_SEL] ? addr_ff[7:1]
                          : strap_addr_ff;
      power_down_ff <= strap_done_ff && sleep_ff && !link_detect;
      video_reset_ff <= vid_go || vid_cnt_ff > 4'h1;
      logic_reset_ff <= dig_go || dig_cnt_ff > 4'h1;
      crc_check_en_ff <= gcfg_ff[`SCR_B_CRC_EN];
      auto_ack_ff <= gcfg_ff[`SCR_B_AUTO_ACK];
      sync_filter_en_ff <= gcfg_ff[`SCR_B_SYNC_FILT];
      use_osc_ff <= gcfg_ff[`SCR_B_CLK_AUTO] && !pclk_present;
      failsafe_low_ff <= fsel_ff[`SCR_B_FS_LOW];
      sda_delay_ns_ff <= 9'(`SCR_SDA_BASE_NS)
        + 9'(bctl_ff[4:3]) * 9'(`SCR_SDA_STEP_NS);
    end
  end

  wire [2:0] pin_mode [3];
  wire [2:0] pin_val = {pin12_ff[7], pin12_ff[3], pin0_ff[3]};
  wire [2:0] pin_func;
  assign pin_mode[0] = pin0_ff[2:0];
  assign pin_mode[1] = pin12_ff[2:0];
  assign pin_mode[2] = pin12_ff[6:4];
  assign pin2_func_in = pin_func[2];
  for (genvar g = 0; g < 3; g++)
  begin : g_pin
    scr_gpio_pin #(.FUNC_IN(g == 2)) u_pin (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .mode(pin_mode[g]),
      .out_val(pin_val[g]),
      .remote_val(gpio_remote[g]),
      .link_up(link_detect),
      .pin_out_ff(gpio_out[g]),
      .pin_oe_ff(gpio_oe[g]),
      .func_in_ff(pin_func[g])
    );
  end

  AST_OWN_ADDR: assert property (
    strap_done_ff && addr_ff[0] && !wr_own && !full_clr
    |=> ##1 own_bus_address_ff == $past(addr_ff[7:1], 2))
    else $error("programmed address not used");
  AST_SLEEP: assert property (
    strap_done_ff && sleep_ff && !link_detect |=> power_down_ff)
    else $error("no power down without link");
  AST_VID_RST: assert property (
    vid_go ##1 !vid_go [*8] ##1 !vid_go |=> !video_reset_ff)
    else $error("video reset did not end");
  AST_FULL_RST: assert property (
    full_clr |=> gcfg_ff == `SCR_GEN_CFG_RST && fsel_ff == `SCR_FAILSAFE_RST)
    else $error("full reset kept register contents");
  AST_CRC_HOLD: assert property (
    crc_clr |=> crc_cnt_ff == 16'h0000)
    else $error("crc counter not held clear");
  AST_CRC_COUNT: assert property (
    crc_hit && !crc_clr && crc_cnt_ff != 16'hFFFF
    |=> crc_cnt_ff == $past(crc_cnt_ff) + 16'h0001)
    else $error("crc error not counted");
  AST_LINK_LOST: assert property (
    link_fall |=> link_lost_ff ##1 (link_lost_ff || $past(crc_clr)))
    else $error("link lost flag not sticky");
  AST_BIST_CLR: assert property (
    bist_start && !(crc_hit && bist_active) |=> !bist_err_ff)
    else $error("bist flag survived restart");
  AST_REM_BLOCK: assert property (
    reg_req && reg_we && reg_remote && bctl_ff[2]
    |=> reg_refused_ff && $stable(gcfg_ff))
    else $error("remote write not blocked");
  AST_REMAP: assert property (
    xl_req && alias_hit |=> xl_fwd_ff && xl_addr_ff == $past(tgt_ff))
    else $error("alias not remapped");
  AST_BUS_CLR: assert property (
    bc_state_ff == scr_pkg::SCR_BC_WATCH ##1
    bc_state_ff == scr_pkg::SCR_BC_LOW |-> scl_oe_ff && !bus_free_ff)
    else $error("bus clear not driving scl");
  AST_FAILSAFE: assert property (
    wr_fsel && !reg_wdata[7] |=> ##1 !failsafe_low_ff)
    else $error("failsafe level not applied");

  COV_FULL_RST: cover property (full_clr ##1 dig_cnt_ff != 4'h0);
  COV_BUS_CLR: cover property (bc_state_ff == scr_pkg::SCR_BC_HIGH);
  COV_REMAP: cover property (xl_req && alias_hit);
  COV_LINK_LOST: cover property (link_fall ##1 crc_clr);

endmodule

// [tb/scr_far_end.sv]
// far side stand-in: link, receiver lock, learned address, crc errors
// assumes the bench commands link state and error bursts on clk_sys
`timescale 1ns/10ps
module scr_far_end (
  input wire logic clk_sys,
  input wire logic link_cmd,
  input wire logic err_cmd,
  output logic link_detect,
  output logic rx_lock,
  output logic [6:0] remote_rx_addr,
  output logic crc_error,
  output logic pclk_present,
  output logic [2:0] gpio_remote
);
  initial
  begin
    link_detect = 1'b0;
    rx_lock = 1'b0;
    crc_error = 1'b0;
    gpio_remote = 3'h0;
  end
  assign remote_rx_addr = 7'h2C;
  assign pclk_present = 1'b1;
  // lock trails link by a cycle; errors come as isolated one-cycle pulses
  always @(posedge clk_sys)
  begin
    link_detect <= link_cmd;
    rx_lock <= link_detect & link_cmd;
    crc_error <= err_cmd & ~crc_error;
    gpio_remote <= gpio_remote + 3'h1;
  end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the control register bank
// assumes scr_far_end stands in for the link partner
`timescale 1ns/10ps
module tb_top;
  logic clk_sys, resetn, reg_req, reg_we, reg_remote, refused;
  logic link_cmd, err_cmd, xl_req, scl_in, sda_in;
  logic [7:0] reg_addr, reg_wdata, rdata, reg_rdata_ff;
  logic link_detect, rx_lock, crc_error, pclk_present;
  logic reg_ack_ff, reg_refused_ff, xl_fwd_ff, video_reset_ff, bus_free_ff;
  logic [6:0] remote_rx_addr, xl_addr, xl_addr_ff, own_bus_address_ff;
  logic [2:0] gpio_remote, gpio_out, gpio_oe;
  logic [8:0] sda_delay_ns_ff;
  logic scl_oe_ff, power_down_ff, failsafe_low_ff, bist_active, bist_start;
  int fails, n_checks, cyc;

  scr_far_end far (.clk_sys, .link_cmd, .err_cmd, .link_detect, .rx_lock,
    .remote_rx_addr, .crc_error, .pclk_present, .gpio_remote);

  // short idle count keeps the bus-free wait inside the run
  scr_regs #(.IDLE_CYCLES(20)) dut (.clk_sys, .resetn, .reg_req, .reg_we,
    .reg_remote, .reg_addr, .reg_wdata, .reg_rdata_ff, .reg_ack_ff,
    .reg_refused_ff, .address_strap_pin(7'h0C), .mode_strap_zero(1'b0),
    .scl_in, .sda_in, .scl_out_ff(), .scl_oe_ff, .bus_free_ff,
    .link_detect, .rx_lock, .remote_rx_addr, .crc_error,
    .bist_active, .bist_start, .pclk_present, .xl_req,
    .xl_addr, .xl_done_ff(), .xl_fwd_ff, .xl_addr_ff, .gpio_remote,
    .gpio_out, .gpio_oe, .pin2_func_in(), .own_bus_address_ff,
    .power_down_ff, .video_reset_ff, .logic_reset_ff(),
    .crc_check_en_ff(), .auto_ack_ff(), .sync_filter_en_ff(),
    .use_osc_ff(), .failsafe_low_ff, .sda_delay_ns_ff);

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one request held for one edge; the ack must follow at the next edge
  task automatic req(input logic we, input logic rem, input logic [7:0] a,
      input logic [7:0] d);
    reg_we = we;
    reg_remote = rem;
    reg_addr = a;
    reg_wdata = d;
    reg_req = 1'b1;
    @(negedge clk_sys);
    chk(reg_ack_ff, 1'b1);
    rdata = reg_rdata_ff;
    refused = reg_refused_ff;
    // an idle edge keeps a following call from re-raising req at once
    reg_req = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req(1'b0, 1'b0, a, 8'h00);
    chk(rdata, exp);
  endtask

  task automatic xl(input logic [6:0] a);
    xl_addr = a;
    xl_req = 1'b1;
    @(negedge clk_sys);
    xl_req = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic t_defaults;
    rd(8'h03, 8'hD2);
    rd(8'h04, 8'h80);
    rd(8'h02, 8'h00);
    rd(8'h06, 8'h58);
    chk(bus_free_ff, 1'b1);
    chk(failsafe_low_ff, 1'b1);
  endtask

  task automatic t_addr;
    wr(8'h00, 8'h55);
    repeat (2) @(negedge clk_sys);
    chk(own_bus_address_ff, 7'h2A);
    wr(8'h00, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk(own_bus_address_ff, 7'h0C);
  endtask

  task automatic t_crc;
    err_cmd = 1'b1;
    repeat (6) @(negedge clk_sys);
    err_cmd = 1'b0;
    repeat (2) @(negedge clk_sys);
    rd(8'h0A, 8'h03);
    rd(8'h0B, 8'h00);
    rd(8'h0C, 8'h07);
    wr(8'h04, 8'h20);
    rd(8'h0A, 8'h00);
    rd(8'h0C, 8'h05);
    rd(8'h04, 8'h20);
    chk(failsafe_low_ff, 1'b0);
    wr(8'h04, 8'h80);
    link_cmd = 1'b0;
    repeat (3) @(negedge clk_sys);
    rd(8'h0C, 8'h14);
    link_cmd = 1'b1;
  endtask

  // one error while bist runs, then a bist restart clears the flag
  task automatic t_bist;
    bist_active = 1'b1;
    err_cmd = 1'b1;
    repeat (2) @(negedge clk_sys);
    err_cmd = 1'b0;
    repeat (2) @(negedge clk_sys);
    rd(8'h0C, 8'h1D);
    bist_start = 1'b1;
    @(negedge clk_sys);
    {bist_active, bist_start} = 2'b00;
    rd(8'h0C, 8'h15);
  endtask

  task automatic t_xlate;
    wr(8'h03, 8'hDA);
    wr(8'h07, 8'h66);
    wr(8'h08, 8'h42);
    xl(7'h21);
    chk({xl_fwd_ff, xl_addr_ff}, {1'b1, 7'h33});
    wr(8'h08, 8'h00);
    xl(7'h00);
    chk(xl_fwd_ff, 1'b0);
  endtask

  task automatic t_block;
    wr(8'h05, 8'h04);
    req(1'b1, 1'b1, 8'h07, 8'h10);
    chk(refused, 1'b1);
    rd(8'h07, 8'h66);
    wr(8'h05, 8'h08);
    repeat (2) @(negedge clk_sys);
    chk(sda_delay_ns_ff, 9'h118);
  endtask

  task automatic t_soft;
    wr(8'h01, 8'h10);
    @(negedge clk_sys);
    chk(video_reset_ff, 1'b1);
    rd(8'h01, 8'h10);
    repeat (10) @(negedge clk_sys);
    chk(video_reset_ff, 1'b0);
    rd(8'h01, 8'h00);
    wr(8'h01, 8'h02);
    rd(8'h01, 8'h02);
    rd(8'h03, 8'hD2);
  endtask

  task automatic t_gpio;
    wr(8'h0D, 8'h09);
    wr(8'h0E, 8'h90);
    repeat (2) @(negedge clk_sys);
    chk({gpio_oe[0], gpio_out[0]}, 2'b11);
    chk({gpio_oe[2], gpio_out[2]}, 2'b11);
    rd(8'h0D, 8'h19);
    // remote-default: follows the far side, falls back on link loss
    wr(8'h0D, 8'h0F);
    chk(gpio_out[0], !gpio_remote[0]);
    wr(8'h01, 8'h80);
    link_cmd = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({gpio_oe[0], gpio_out[0]}, 2'b11);
    chk(power_down_ff, 1'b1);
    link_cmd = 1'b1;
  endtask

  // stuck-low data line: clock-out starts after the 20-cycle idle count
  task automatic t_bus;
    sda_in = 1'b0;
    repeat (30) @(negedge clk_sys);
    chk({scl_oe_ff, bus_free_ff}, 2'b10);
    repeat (50) @(negedge clk_sys);
    chk(scl_oe_ff, 1'b0);
    sda_in = 1'b1;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      results();
    end
  end

  initial
  begin
    {resetn, reg_req, reg_we, reg_remote, link_cmd, err_cmd, xl_req} = 7'h00;
    {bist_active, bist_start} = 2'b00;
    {scl_in, sda_in} = 2'b11;
    {reg_addr, reg_wdata} = 16'h0000;
    xl_addr = 7'h00;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    repeat (6) @(negedge clk_sys);
    link_cmd = 1'b1;
    repeat (30) @(negedge clk_sys);
    t_defaults();
    t_addr();
    t_crc();
    t_bist();
    t_xlate();
    t_block();
    t_soft();
    t_gpio();
    t_bus();
    results();
  end
endmodule
